// >>> hdl/pbm_map.vh
`ifndef PBM_MAP_VH
`define PBM_MAP_VH
// Register addresses (8-bit register index)
`define PBM_ADDR_CONFIG   8'h26
`define PBM_ADDR_STATUS   8'h27
// Configuration field positions
`define PBM_CFG_CLEAR_HOLD_TIMER     5
`define PBM_CFG_CLEAR_FAULT_TIMER    4
`define PBM_CFG_FLT_HI    3
`define PBM_CFG_FLT_LO    0
// Status field positions
`define PBM_ST_LEVEL      4
`define PBM_ST_HT_HI      3
`define PBM_ST_HT_LO      0
// Reset values
`define PBM_CONFIG_RESET  8'h08
`define PBM_STATUS_RESET  8'h10
// Timing figures and clock rate
`define PBM_CLK_KHZ       250000
`define PBM_DEBOUNCE_MS   30
`define PBM_WAKE_MS       36
`define PBM_HALF_SEC_MS   500
`define PBM_DEBOUNCE_CYC  (`PBM_DEBOUNCE_MS * `PBM_CLK_KHZ)
`define PBM_WAKE_CYC      (`PBM_WAKE_MS * `PBM_CLK_KHZ)
`define PBM_HALF_SEC_CYC  (`PBM_HALF_SEC_MS * `PBM_CLK_KHZ)
`endif

// >>> hdl/pbm_power_button_monitor.v
`timescale 1ns/100ps
`include "pbm_map.vh"
// Contract
// - Debounce the active-low button for 30 ms; shorter bounce is ignored.
// - A falling edge of the debounced level may start leaving full-off.
// - In full-off, a press over 36 ms powers on and releases resume reset.
// - While on, holding beyond the fault time forces an orderly shutdown; a press still held at rails-up is exempt until a new press or bit 4 write.
// - Host button output always follows the debounced level.
// - Hold timer counts press duration in half-seconds, shown in status.
// - Hold count keeps value after release until next press or clear.
// - Non-zero fault field matching the hold count triggers shutdown; zero disables.
// - Fault field is half-second steps, zero disabled, resets to 1000.
// - Writing one to config bit 5 resets hold timer; reads zero.
// - Writing one to config bit 4 resets fault timer; reads zero. The code only re-arms fault shutdown while on; hold count is kept.
// - Status bit 4 shows debounced level, zero pressed, resets to one.
// - Configuration reset contents come from one-time-programmable memory.
// - Orderly shutdown requests rails off in programmed order.
module pbm_power_button_monitor #(
   parameter DEBOUNCE_CYC = `PBM_DEBOUNCE_CYC,
   parameter WAKE_CYC     = `PBM_WAKE_CYC,
   parameter HALF_SEC_CYC = `PBM_HALF_SEC_CYC,
   parameter CNT_W        = 28
) (
   // Clock and reset
   input  wire       clk_i,
   input  wire       rst_i,
   // Push-button and host side
   input  wire       button_in_n_i,
   output wire       button_to_host_n_o,
   output wire       resume_reset_n_o,
   // Power sequencer side
   input  wire [7:0] otp_config_i,
   input  wire       rails_up_i,
   input  wire       rails_down_i,
   output wire       power_on_req_o,
   output wire       shutdown_req_o,
   // Register port
   input  wire [7:0] reg_addr_i,
   input  wire       reg_wr_i,
   input  wire [7:0] reg_wdata_i,
   output wire [7:0] reg_rdata_o
);

   // Power state codes
   localparam ST_OFF      = 2'd0;
   localparam ST_WAKING   = 2'd1;
   localparam ST_ON       = 2'd2;
   localparam ST_STOPPING = 2'd3;
   // Fault field power-up value, narrowed to the field width below
   localparam [7:0] CFG_RST = `PBM_CONFIG_RESET;

   // Debounce filter
   reg [CNT_W-1:0] db_cnt_ff;
   reg [CNT_W-1:0] nxt_db_cnt;
   reg             level_ff;
   reg             nxt_level;
   reg             level_d_ff;
   // Hold timer
   reg [CNT_W-1:0] tick_cnt_ff;
   reg [CNT_W-1:0] nxt_tick_cnt;
   reg [3:0]       ht_ff;
   reg [3:0]       nxt_ht;
   // Fault field and its one-time load
   reg [3:0]       flt_ff;
   reg             otp_load_ff;
   // Power state machine
   reg [1:0]       state_ff;
   reg [1:0]       nxt_state;
   reg [CNT_W-1:0] wake_cnt_ff;
   reg [CNT_W-1:0] nxt_wake_cnt;
   reg             wake_arm_ff;
   reg             nxt_wake_arm;
   reg             rsm_n_ff;
   reg             nxt_rsm_n;
   reg             pon_ff;
   reg             nxt_pon;
   reg             sdn_ff;
   reg             nxt_sdn;
   reg             fault_arm_ff;
   reg             nxt_fault_arm;
   // Register read data
   reg [7:0]       rdata_ff;

   // Register decode and event terms
   wire             wr_cfg   = reg_wr_i & (reg_addr_i == `PBM_ADDR_CONFIG);
   wire             clr_ht   = wr_cfg & reg_wdata_i[`PBM_CFG_CLEAR_HOLD_TIMER];
   wire             clr_flt  = wr_cfg & reg_wdata_i[`PBM_CFG_CLEAR_FAULT_TIMER];
   wire [CNT_W-1:0] one_cnt  = {{(CNT_W-1){1'b0}}, 1'b1};
   wire [CNT_W-1:0] db_last  = DEBOUNCE_CYC[CNT_W-1:0] - one_cnt;
   wire [CNT_W-1:0] wake_lim = WAKE_CYC[CNT_W-1:0] - DEBOUNCE_CYC[CNT_W-1:0];
   wire             press    = level_d_ff & ~level_ff;
   wire             tick     = (tick_cnt_ff == HALF_SEC_CYC[CNT_W-1:0] - one_cnt);
   wire             match    = (flt_ff != 4'h0) & (ht_ff == flt_ff) & ~level_ff;

   // Debounce next value: raw level must hold steady for the full window before it is taken
   always @*
   begin
      nxt_db_cnt = db_cnt_ff + one_cnt;
      nxt_level  = level_ff;
      if (button_in_n_i == level_ff)
         nxt_db_cnt = {CNT_W{1'b0}}; // Any return to the old level restarts the window
      else if (db_cnt_ff == db_last)
      begin
         nxt_db_cnt = {CNT_W{1'b0}};
         nxt_level  = button_in_n_i;
      end
   end

   // Debounce registers; released level after reset so no false press follows it
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         db_cnt_ff  <= {CNT_W{1'b0}};
         level_ff   <= 1'b1;
         level_d_ff <= 1'b1;
      end
      else
      begin
         db_cnt_ff  <= nxt_db_cnt;
         level_ff   <= nxt_level;
         level_d_ff <= level_ff;
      end
   end

   // Hold timer next value: restarts on each press, freezes on release, saturates at 7.5 s
   always @*
   begin
      nxt_tick_cnt = tick_cnt_ff;
      nxt_ht       = ht_ff;
      if (clr_ht)
      begin
         nxt_tick_cnt = {CNT_W{1'b0}};
         nxt_ht       = 4'h0;
      end
      else if (press)
      begin
         nxt_tick_cnt = {CNT_W{1'b0}};
         nxt_ht       = 4'h0;
      end
      else if (!level_ff)
      begin
         if (tick)
         begin
            nxt_tick_cnt = {CNT_W{1'b0}};
            if (ht_ff != 4'hf)
               nxt_ht = ht_ff + 4'h1;
         end
         else
            nxt_tick_cnt = tick_cnt_ff + one_cnt;
      end
   end

   // Hold timer registers; a software clear beats a same-cycle press or tick
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tick_cnt_ff <= {CNT_W{1'b0}};
         ht_ff       <= 4'h0;
      end
      else
      begin
         tick_cnt_ff <= nxt_tick_cnt;
         ht_ff       <= nxt_ht;
      end
   end

   // Fault field: loaded from OTP one cycle after reset release, then software owned
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         flt_ff      <= CFG_RST[3:0];
         otp_load_ff <= 1'b1;
      end
      else if (otp_load_ff)
      begin
         flt_ff      <= otp_config_i[`PBM_CFG_FLT_HI:`PBM_CFG_FLT_LO];
         otp_load_ff <= 1'b0;
      end
      else if (wr_cfg)
         flt_ff <= reg_wdata_i[`PBM_CFG_FLT_HI:`PBM_CFG_FLT_LO];
   end

   // Power state next values; wake only counts after a fresh press, so a button
   // still held through a forced shutdown cannot power the system straight back on
   always @*
   begin
      nxt_state     = state_ff;
      nxt_wake_cnt  = wake_cnt_ff;
      nxt_wake_arm  = wake_arm_ff;
      nxt_rsm_n     = rsm_n_ff;
      nxt_pon       = 1'b0;
      nxt_sdn       = 1'b0;
      nxt_fault_arm = fault_arm_ff;
      case (state_ff)
         ST_OFF:
         begin
            nxt_rsm_n = 1'b0;
            if (press)
            begin
               nxt_wake_cnt = {CNT_W{1'b0}};
               nxt_wake_arm = 1'b1;
            end
            else if (level_ff)
               nxt_wake_arm = 1'b0; // Released before the wake window ended
            else if (wake_arm_ff)
            begin
               if (wake_cnt_ff >= wake_lim)
               begin
                  nxt_pon      = 1'b1;
                  nxt_wake_arm = 1'b0;
                  nxt_state    = ST_WAKING;
               end
               else
                  nxt_wake_cnt = wake_cnt_ff + one_cnt;
            end
         end
         ST_WAKING:
         begin
            if (rails_up_i)
            begin
               nxt_rsm_n     = 1'b1;
               nxt_fault_arm = level_ff;
               nxt_state     = ST_ON;
            end
         end
         ST_ON:
         begin
            if (clr_flt || press)
               nxt_fault_arm = 1'b1;
            if (match && fault_arm_ff && !clr_flt)
            begin
               nxt_sdn       = 1'b1;
               nxt_fault_arm = 1'b0;
               nxt_state     = ST_STOPPING;
            end
         end
         ST_STOPPING:
         begin
            if (rails_down_i)
            begin
               nxt_rsm_n    = 1'b0;
               nxt_wake_cnt = {CNT_W{1'b0}};
               nxt_wake_arm = 1'b0;
               nxt_state    = ST_OFF;
            end
         end
         default:
            nxt_state = ST_OFF;
      endcase
   end

   // Power state registers
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_ff     <= ST_OFF;
         wake_cnt_ff  <= {CNT_W{1'b0}};
         wake_arm_ff  <= 1'b0;
         rsm_n_ff     <= 1'b0;
         pon_ff       <= 1'b0;
         sdn_ff       <= 1'b0;
         fault_arm_ff <= 1'b1;
      end
      else
      begin
         state_ff     <= nxt_state;
         wake_cnt_ff  <= nxt_wake_cnt;
         wake_arm_ff  <= nxt_wake_arm;
         rsm_n_ff     <= nxt_rsm_n;
         pon_ff       <= nxt_pon;
         sdn_ff       <= nxt_sdn;
         fault_arm_ff <= nxt_fault_arm;
      end
   end

   // Read data registered; reserved and self-clearing bits read as zero
   always @(posedge clk_i)
   begin
      if (rst_i)
         rdata_ff <= 8'h00;
      else if (reg_addr_i == `PBM_ADDR_CONFIG)
         rdata_ff <= {4'h0, flt_ff};
      else if (reg_addr_i == `PBM_ADDR_STATUS)
         rdata_ff <= {3'h0, level_ff, ht_ff};
      else
         rdata_ff <= 8'h00;
   end

   assign button_to_host_n_o = level_ff;
   assign resume_reset_n_o   = rsm_n_ff;
   assign power_on_req_o     = pon_ff;
   assign shutdown_req_o     = sdn_ff;
   assign reg_rdata_o        = rdata_ff;

endmodule // pbm_power_button_monitor

// >>> verification/pbm_monitor.sv
`timescale 1ns/100ps
module pbm_monitor (
   // Clock and reset
   input wire       clk_i,
   input wire       rst_i,
   // Button, power and register ports
   input wire       button_in_n_i,
   input wire       button_to_host_n_o,
   input wire       resume_reset_n_o,
   input wire [7:0] otp_config_i,
   input wire       rails_up_i,
   input wire       rails_down_i,
   input wire       power_on_req_o,
   input wire       shutdown_req_o,
   input wire [7:0] reg_addr_i,
   input wire       reg_wr_i,
   input wire [7:0] reg_wdata_i,
   input wire [7:0] reg_rdata_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // A falling level needs the raw input already low seven samples earlier
   property p_db; $fell(button_to_host_n_o) |-> !$past(button_in_n_i,7); endproperty
   a_db: assert property (p_db) else $error("bounce passed");
   property p_lv; reg_addr_i == 8'h27 |=> reg_rdata_o[4] == $past(button_to_host_n_o); endproperty
   a_lv: assert property (p_lv) else $error("level bit");
   property p_un; reg_addr_i[7:1] != 7'h13 |=> reg_rdata_o == 8'h00; endproperty
   a_un: assert property (p_un) else $error("unmapped read");
   property p_cf; reg_addr_i == 8'h26 |=> reg_rdata_o[7:4] == 4'h0; endproperty
   a_cf: assert property (p_cf) else $error("clear bits read");
   property p_st; reg_addr_i == 8'h27 |=> reg_rdata_o[7:5] == 3'h0; endproperty
   a_st: assert property (p_st) else $error("status spare");
   property p_on; power_on_req_o |-> !resume_reset_n_o ##1 !power_on_req_o; endproperty
   a_on: assert property (p_on) else $error("wake pulse");
   property p_rr; $rose(resume_reset_n_o) |-> $past(rails_up_i); endproperty
   a_rr: assert property (p_rr) else $error("early resume");
   property p_sd; shutdown_req_o |-> $past(!button_to_host_n_o) ##1 !shutdown_req_o; endproperty
   a_sd: assert property (p_sd) else $error("shutdown pulse");
endmodule // pbm_monitor

bind pbm_power_button_monitor pbm_monitor u_mon (.*);

// >>> verification/pbm_seq_model.sv
`timescale 1ns/100ps
module pbm_seq_model (
   // Requests from the block and rail status back
   input  wire clk_i,
   input  wire on_i,
   input  wire off_i,
   output reg  up_o = 1'b0,
   output reg  down_o = 1'b1
);
   reg [2:0] cnt_ff = 3'h0;
   reg       tgt_ff = 1'b0;
   // Rails drop before the sequence reports done, never both at once
   always @(posedge clk_i)
   begin
      cnt_ff <= (on_i || off_i) ? 3'h5 : cnt_ff - {2'h0, cnt_ff != 3'h0};
      if (on_i || off_i)
         tgt_ff <= on_i;
      if (off_i)
         up_o <= 1'b0;
      if (on_i)
         down_o <= 1'b0;
      if (cnt_ff == 3'h1)
      begin
         up_o <= tgt_ff;
         down_o <= !tgt_ff;
      end
   end
endmodule // pbm_seq_model

// >>> verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   reg         clk_i = 1'b0;
   reg         rst_i = 1'b1;
   reg         btn_n = 1'b1;
   reg         wr    = 1'b0;
   reg  [7:0]  addr  = 8'h00;
   reg  [7:0]  wdat  = 8'h00;
   wire [7:0]  rdat;
   wire        host_n, rr_n, pon, sdn, up, dn;
   integer     err_total = 0;
   integer     total_checks = 0;
   integer     sd_cnt = 0;
   integer     i;
   pbm_power_button_monitor #(.DEBOUNCE_CYC(8), .WAKE_CYC(10), .HALF_SEC_CYC(16)) uut (
      .clk_i(clk_i), .rst_i(rst_i), .button_in_n_i(btn_n), .button_to_host_n_o(host_n),
      .resume_reset_n_o(rr_n), .otp_config_i(8'h03), .rails_up_i(up), .rails_down_i(dn),
      .power_on_req_o(pon), .shutdown_req_o(sdn), .reg_addr_i(addr), .reg_wr_i(wr),
      .reg_wdata_i(wdat), .reg_rdata_o(rdat));
   pbm_seq_model u_seq (.clk_i(clk_i), .on_i(pon), .off_i(sdn), .up_o(up), .down_o(dn));
   // 4 ns clock; shutdown pulses counted so a repeat fire shows up
   initial forever #2 clk_i = ~clk_i;
   always @(posedge clk_i) if (sdn) sd_cnt = sd_cnt + 1;
   task chk(input [7:0] got, input [7:0] exp);
   begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
         err_total = err_total + 1;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   end
   endtask
   // Register access; inputs move on the falling edge
   task wreg(input [7:0] a, input [7:0] d);
   begin
      @(negedge clk_i) addr = a;
      wdat = d;
      wr = 1'b1;
      @(negedge clk_i) wr = 1'b0;
   end
   endtask
   task rreg(input [7:0] a, input [7:0] e);
   begin
      @(negedge clk_i) addr = a;
      @(negedge clk_i) chk(rdat, e);
   end
   endtask
   // Press for n cycles, then leave time for the release to filter through
   task press(input integer n);
   begin
      btn_n = 1'b0;
      repeat (n) @(negedge clk_i);
      btn_n = 1'b1;
      repeat (12) @(negedge clk_i);
   end
   endtask
   task complete_run;
   begin
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   end
   endtask
   // Main sequence
   initial
   begin
      repeat (2) @(negedge clk_i);
      rst_i = 1'b0;
      @(negedge clk_i);
      rreg(8'h26, 8'h03);
      rreg(8'h27, 8'h10);
      rreg(8'h25, 8'h00);
      wreg(8'h27, 8'hff);
      rreg(8'h27, 8'h10);
      press(5);
      chk({7'h0, host_n}, 8'h01);
      btn_n = 1'b0;
      for (i = 0; i < 100 && pon !== 1'b1; i = i + 1)
         @(negedge clk_i);
      chk({7'h0, pon}, 8'h01);
      chk({6'h0, host_n, rr_n}, 8'h00);
      for (i = 0; i < 100 && rr_n !== 1'b1; i = i + 1)
         @(negedge clk_i);
      chk({7'h0, rr_n}, 8'h01);
      btn_n = 1'b1;
      repeat (12) @(negedge clk_i);
      chk({7'h0, host_n}, 8'h01);
      wreg(8'h26, 8'h20);
      wreg(8'h26, 8'h00);
      press(36);
      rreg(8'h27, 8'h12);
      repeat (20) @(negedge clk_i);
      rreg(8'h27, 8'h12);
      wreg(8'h26, 8'h20);
      rreg(8'h27, 8'h10);
      wreg(8'h26, 8'h11);
      rreg(8'h26, 8'h01);
      press(40);
      chk(sd_cnt[7:0], 8'h01);
      for (i = 0; i < 100 && rr_n !== 1'b0; i = i + 1)
         @(negedge clk_i);
      chk({7'h0, rr_n}, 8'h00);
      complete_run;
   end
   // Watchdog
   initial
   begin
      #100000;
      err_total = err_total + 1;
      complete_run;
   end
endmodule // tb_top
